// ==== common/idc_pkg.sv ====
/*
  Package for the idle domain controller: register offsets, field positions,
  reset values, the packed struct that carries domain state and the Wishbone request bundle.
  Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
// Notes on behaviour
// - Group idle request gates masked peripherals on idle
// - Group request clear wakes all peripherals
// - Cache request bit idles instruction cache
// - Master request bit idles the master domain (status bit 1)
// - Processor request bit idles the core
// - Status bit 8 shows fetch port idle
// - Status bit 7 shows DMA/host port idle
// - Status bit 6 shows I/O port idle
// - Status bit 5 shows external memory idle
// - Status bit 4 shows clock generator idle
// - Status bit 3 shows peripheral group idle
// - Status bits 2..0 show cache, master, core
// - Mask bit 13 gates auxiliary register group
// - Mask bit 12 gates external memory interface
// - Mask bit 11 gates OS tick timer
// - Mask bit 10 gates watchdog timer
// - Mask bit 9 gates parallel I/O
// - Mask bit 8 gates UART
// - Mask bit 7 gates I2C controller
// - Idle with group request cleared wakes all
// - Idle with group request set wakes unmasked
// - Clock idle without full confirm raises bus error
// - Mask bits 6..0 gate remaining peripherals
package idc_pkg;
  // Byte offsets of the registers on the bus.
  localparam logic [15:0] IDC_OFS_CONFIG = 16'h0000;
  localparam logic [15:0] IDC_OFS_STATUS = 16'h0002;
  localparam logic [15:0] IDC_OFS_GATE = 16'h9400;
  localparam logic [15:0] IDC_OFS_GATE_STAT = 16'h9401;
  // Decoder width used by the bus slave.
  localparam int IDC_ADDR_W = 16;
  // Configuration word field positions.
  localparam int IDC_B_CPU = 0;
  localparam int IDC_B_MASTER = 1;
  localparam int IDC_B_CACHE = 2;
  localparam int IDC_B_GROUP = 3;
  localparam int IDC_B_CLK = 4;
  localparam int IDC_B_EXT_MEMORY_PORT = 5;
  localparam int IDC_B_IO_SPACE_PORT = 6;
  localparam int IDC_B_DMA_HOST_PORT = 7;
  localparam int IDC_B_INSTR_FETCH_PORT = 8;
  localparam int IDC_B_CLK_CONFIRM = 9;
  // Writable bits of the configuration and gate mask registers; others read zero.
  localparam logic [15:0] IDC_CONFIG_MASK = 16'h03ff;
  localparam logic [15:0] IDC_GATE_MASK = 16'h3fff;
  // Bits that must all be set when the clock generator is idled.
  localparam logic [15:0] IDC_CLK_NEEDS = 16'h03e7;
  localparam logic [15:0] IDC_CONFIG_RESET = 16'h0000;
  localparam logic [15:0] IDC_GATE_RESET = 16'h0000;
  localparam logic [15:0] IDC_STATUS_RESET = 16'h0000;
  // Number of gated peripheral lines.
  localparam int IDC_NUM_PERIPH = 14;

  // Disabled state of each main domain, laid out as the status word bits 8..0.
  typedef struct packed {
    logic instr_fetch_port;
    logic dma_host_port;
    logic io_space_port;
    logic ext_memory_port;
    logic clk;
    logic group;
    logic cache;
    logic master;
    logic cpu;
  } idc_domain_t;

  // Classic Wishbone request bundle.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [IDC_ADDR_W-1:0] adr;
    logic [31:0] dat;
  } idc_wb_req_t;
endpackage

// ==== hdl/idc_wb_slave.sv ====
/*
  Classic Wishbone slave front end for the idle domain controller.
  Assumes a single-cycle master that holds its request until ack.
  Ack comes one cycle after the request is seen and drops the next cycle.
*/
module idc_wb_slave
  import idc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire idc_pkg::idc_wb_req_t req_i,
  input wire logic [31:0] rd_data_i,
  output logic ack_o,
  output logic err_o,
  output logic [31:0] dat_o,
  output logic wr_o,
  output logic [IDC_ADDR_W-1:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] wdat_o,
  input wire logic hit_i
);
  import idc_pkg::*;
  // A request that is live and not yet answered.
  logic ack;
  logic err;
  wire start = req_i.cyc & req_i.stb & ~ack & ~err;

  // Register the answer so each access takes exactly one wait cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack <= 1'b0;
      err <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      // Unmapped addresses answer with err so software sees the mistake.
      ack <= start & hit_i;
      err <= start & ~hit_i;
      dat_o <= (start & hit_i & ~req_i.we) ? rd_data_i : 32'h0000_0000;
    end
  end

  assign ack_o = ack;
  assign err_o = err;
  // Writes land at the edge where the master samples ack high, not one earlier.
  // The master still holds address and data there, so the decode stays valid.
  assign wr_o = ack & req_i.cyc & req_i.stb & req_i.we;
  assign adr_o = req_i.adr;
  assign sel_o = req_i.sel;
  assign wdat_o = req_i.dat;
endmodule

// ==== hdl/idc_gate_bank.sv ====
/*
  Bank of peripheral gate flops: one disable flag per gated peripheral.
  Assumes the caller presents one idle strobe per executed idle instruction.
*/
module idc_gate_bank
  import idc_pkg::*;
#(
  parameter int N = IDC_NUM_PERIPH
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic idle_i,
  input wire logic group_req_i,
  input wire logic [N-1:0] mask_i,
  output logic [N-1:0] off_o
);
  import idc_pkg::*;
  // The gate status word is 16 bits wide, so more lines cannot be reported.
  if (N < 1 || N > 16)
  begin : g_bad_n
    $error("idc_gate_bank: N out of range");
  end

  // On each idle, every peripheral takes its mask bit only while the group request is set.
  for (genvar i = 0; i < N; i++)
  begin : g_gate
    // Next state on an idle: masked lines stop if the group request is set, all other lines wake.
    wire next_off = group_req_i & mask_i[i];
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        off_o[i] <= 1'b0;
      end
      else if (idle_i)
      begin
        off_o[i] <= next_off;
      end
    end
  end
endmodule

// ==== hdl/idc_top.sv ====
/*
  Idle domain controller top level.
  Holds the idle configuration word, the peripheral gate mask and the
  status words, and applies them when the core executes an idle instruction.
  Assumes idle_exec_i is a one-cycle pulse per idle instruction, synchronous
  to clk_i, and that gated modules obey their disable outputs.
*/
// The Wishbone register port was chosen for this implementation.
module idc_top
  import idc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [idc_pkg::IDC_ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic idle_exec_i,
  output idc_pkg::idc_domain_t domain_off_o,
  output logic [idc_pkg::IDC_NUM_PERIPH-1:0] periph_off_o,
  output logic bus_error_o
);
  import idc_pkg::*;

  // Software-visible registers.
  logic [15:0] idle_config_word;
  logic [15:0] group_gate_mask;
  idc_domain_t dom;
  logic bus_error;

  // Bus front end wires.
  idc_wb_req_t req;
  logic wr;
  logic [IDC_ADDR_W-1:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rd_data;
  logic hit;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};

  idc_wb_slave u_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(req),
    .rd_data_i(rd_data),
    .ack_o(wb_ack_o),
    .err_o(wb_err_o),
    .dat_o(wb_dat_o),
    .wr_o(wr),
    .adr_o(adr),
    .sel_o(sel),
    .wdat_o(wdat),
    .hit_i(hit)
  );

  // Address decode, one wire per register.
  wire sel_cfg = (adr == IDC_OFS_CONFIG);
  wire sel_sta = (adr == IDC_OFS_STATUS);
  wire sel_gate = (adr == IDC_OFS_GATE);
  wire sel_gsta = (adr == IDC_OFS_GATE_STAT);
  assign hit = sel_cfg | sel_sta | sel_gate | sel_gsta;

  // Byte-lane merge for the low 16 bits of a write.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s,
                                          input logic [15:0] m);
    logic [15:0] r;
    r = old;
    if (s[0])
    begin
      r[7:0] = d[7:0];
    end
    if (s[1])
    begin
      r[15:8] = d[15:8];
    end
    return r & m;
  endfunction

  // Status word packed from live domain state; reserved bits read zero.
  wire [15:0] status_word = {7'h00, dom};
  wire [15:0] gate_status = {{(16 - IDC_NUM_PERIPH){1'b0}}, periph_off_o};

  // Read multiplexer; the upper half of each word reads zero.
  assign rd_data = sel_cfg ? {16'h0000, idle_config_word} :
                   sel_sta ? {16'h0000, status_word} :
                   sel_gate ? {16'h0000, group_gate_mask} :
                   sel_gsta ? {16'h0000, gate_status} : 32'h0000_0000;

  // Configuration and gate mask writes only store values; no domain moves.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idle_config_word <= IDC_CONFIG_RESET;
      group_gate_mask <= IDC_GATE_RESET;
    end
    else if (wr)
    begin
      if (sel_cfg)
      begin
        idle_config_word <= merge16(idle_config_word, wdat, sel, IDC_CONFIG_MASK);
      end
      if (sel_gate)
      begin
        group_gate_mask <= merge16(group_gate_mask, wdat, sel, IDC_GATE_MASK);
      end
    end
  end

  // Clock idling is only legal with the confirm bit and every companion bit set.
  wire clk_req = idle_config_word[IDC_B_CLK];
  wire clk_ok = ((idle_config_word & IDC_CLK_NEEDS) == IDC_CLK_NEEDS)
                & idle_config_word[IDC_B_CLK_CONFIRM];
  wire clk_bad = clk_req & ~clk_ok;
  // A refused idle changes nothing, so a bad setup cannot half-stop the chip.
  wire idle_ok = idle_exec_i & ~clk_bad;

  // Next domain state is taken straight from the request bits.
  idc_domain_t next_dom;
  assign next_dom.cpu = idle_config_word[IDC_B_CPU];
  assign next_dom.master = idle_config_word[IDC_B_MASTER];
  assign next_dom.cache = idle_config_word[IDC_B_CACHE];
  assign next_dom.group = idle_config_word[IDC_B_GROUP];
  assign next_dom.clk = clk_req;
  assign next_dom.ext_memory_port = idle_config_word[IDC_B_EXT_MEMORY_PORT];
  assign next_dom.io_space_port = idle_config_word[IDC_B_IO_SPACE_PORT];
  assign next_dom.dma_host_port = idle_config_word[IDC_B_DMA_HOST_PORT];
  assign next_dom.instr_fetch_port = idle_config_word[IDC_B_INSTR_FETCH_PORT];

  // Domains move only on an accepted idle; the bus error is a one-cycle pulse.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dom <= idc_domain_t'(IDC_STATUS_RESET[8:0]);
      bus_error <= 1'b0;
    end
    else
    begin
      bus_error <= idle_exec_i & clk_bad;
      if (idle_ok)
      begin
        dom <= next_dom;
      end
    end
  end

  // Per-peripheral gates: bits 13..7 named modules, 6..0 the rest.
  idc_gate_bank #(
    .N(IDC_NUM_PERIPH)
  ) u_gates (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .idle_i(idle_ok),
    .group_req_i(idle_config_word[IDC_B_GROUP]),
    .mask_i(group_gate_mask[IDC_NUM_PERIPH-1:0]),
    .off_o(periph_off_o)
  );

  assign domain_off_o = dom;
  assign bus_error_o = bus_error;
endmodule

// ==== bench/idc_monitor.sv ====
/* Checker bound to idc_top; shadows both writable registers from bus writes.
   Assumes a single-cycle classic master that holds its request until ack. */
module idc_monitor
  import idc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [idc_pkg::IDC_ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic idle_exec_i,
  input wire idc_pkg::idc_domain_t domain_off_o,
  input wire logic [idc_pkg::IDC_NUM_PERIPH-1:0] periph_off_o,
  input wire logic bus_error_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import idc_pkg::*;
  logic [15:0] cfg;
  logic [15:0] gate;
  // Byte lanes merge the written word into the old one, as the slave does.
  wire logic [15:0] lane = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [15:0] merged = wb_dat_i[15:0] & lane;
  wire logic wr_cfg = wb_ack_o && wb_we_i && wb_adr_i == IDC_OFS_CONFIG;
  wire logic wr_gate = wb_ack_o && wb_we_i && wb_adr_i == IDC_OFS_GATE;
  wire logic [15:0] next_cfg = wr_cfg ? (merged | (cfg & ~lane)) & IDC_CONFIG_MASK : cfg;
  wire logic [15:0] next_gate = wr_gate ? (merged | (gate & ~lane)) & IDC_GATE_MASK : gate;
  // A clock idle request without every companion bit is refused.
  wire logic bad = cfg[IDC_B_CLK] && ((cfg & IDC_CLK_NEEDS) != IDC_CLK_NEEDS);
  wire logic [8:0] cfg_dom = cfg[8:0];
  wire logic [13:0] gate_v = gate[13:0];
  wire logic rd_ack = wb_ack_o && !wb_we_i;
  // Shadow registers follow the writes at the edge where ack is seen.
  always_ff @(posedge clk_i)
  begin
    cfg <= rst_i ? 16'h0000 : next_cfg;
    gate <= rst_i ? 16'h0000 : next_gate;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  hold_still_a: assert property (!idle_exec_i |=>
    $stable(domain_off_o) && $stable(periph_off_o))
    else $error("state moved without idle");
  dom_apply_a: assert property (idle_exec_i && !bad |=>
    domain_off_o == $past(cfg_dom))
    else $error("domain state wrong after idle");
  grp_gate_a: assert property (idle_exec_i && !bad && cfg[3] |=>
    periph_off_o == $past(gate_v))
    else $error("masked peripherals not gated");
  grp_wake_a: assert property (idle_exec_i && !bad && !cfg[3] |=>
    periph_off_o == 14'h0000)
    else $error("peripherals not woken");
  clk_refuse_a: assert property (idle_exec_i && bad |=>
    bus_error_o && $stable(domain_off_o))
    else $error("bad clock idle not refused");
  berr_cause_a: assert property (bus_error_o |-> $past(idle_exec_i) && $past(bad))
    else $error("stray bus error");
  stat_read_a: assert property (rd_ack && wb_adr_i == IDC_OFS_STATUS |->
    wb_dat_o == {23'h0, domain_off_o})
    else $error("status word wrong");
  gate_read_a: assert property (rd_ack && wb_adr_i == IDC_OFS_GATE_STAT |->
    wb_dat_o == {18'h0, periph_off_o})
    else $error("gate status wrong");
  bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=>
    wb_ack_o ^ wb_err_o)
    else $error("no bus answer");
endmodule

// ==== bench/idc_core_model.sv ====
/* Core-side model: executes one idle instruction per call of issue.
   Assumes the bench calls issue from its main thread only. */
module idc_core_model
(
  input wire logic clk_i,
  output logic idle_exec_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial idle_exec_o = 1'b0;
  // The pulse lasts one cycle, so every call is exactly one instruction.
  task automatic issue();
    @(posedge clk_i);
    idle_exec_o <= 1'b1;
    @(posedge clk_i);
    idle_exec_o <= 1'b0;
  endtask
endmodule

// ==== bench/test_idc_top.sv ====
/* Bench for idc_top: a table of idle settings, then register and reset cases.
   Assumes idc_pkg, idc_core_model and idc_monitor are compiled first. */
module test_idc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import idc_pkg::*;
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] gate;
    logic [8:0] dom;
    logic [13:0] per;
    logic err;
  } idc_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [IDC_ADDR_W-1:0] wb_adr_i = 16'h0000;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, d;
  logic wb_ack_o, wb_err_o, idle_exec_i, bus_error_o, e;
  idc_domain_t domain_off_o;
  logic [IDC_NUM_PERIPH-1:0] periph_off_o;
  logic [8:0] ed = 9'h000;
  logic [13:0] ep = 14'h0000;
  int num_errors = 0, compares = 0, cycles = 0;
  // Row 8 asks for clock idle without its companions, so state must hold.
  idc_row_t rows [10] = '{'{16'h0001, 16'h0000, 9'h001, 14'h0000, 1'b0},
    '{16'h0002, 16'h0000, 9'h002, 14'h0000, 1'b0}, '{16'h0004, 16'h0000, 9'h004, 14'h0000, 1'b0},
    '{16'h0008, 16'h3fff, 9'h008, 14'h3fff, 1'b0}, '{16'h0008, 16'h2aaa, 9'h008, 14'h2aaa, 1'b0},
    '{16'h0000, 16'h3fff, 9'h000, 14'h0000, 1'b0}, '{16'h01e0, 16'h0000, 9'h1e0, 14'h0000, 1'b0},
    '{16'h03ff, 16'h1555, 9'h1ff, 14'h1555, 1'b0}, '{16'h0010, 16'h0000, 9'h1ff, 14'h1555, 1'b1},
    '{16'h0000, 16'h0000, 9'h000, 14'h0000, 1'b0}};
  idc_top idc_top_i (.*);
  idc_core_model idc_core_model_i (.clk_i(clk_i), .idle_exec_o(idle_exec_i));
  always #2 clk_i = ~clk_i;
  // A hang ends the run here; the whole plan needs well under 3000 cycles.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One classic cycle: hold everything until ack or err is sampled high.
  task automatic wb(input logic we, input logic [15:0] adr, input logic [3:0] sel,
    input logic [31:0] dat);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'b11, we, sel, adr, dat};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    d = wb_dat_o;
    e = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic rd_chk(input logic [15:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 4'h3, 32'h0);
    chk(d, exp);
  endtask
  task automatic idle();
    idc_core_model_i.issue();
    @(posedge clk_i);
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(IDC_OFS_CONFIG, 32'h0);
    rd_chk(IDC_OFS_STATUS, 32'h0);
    rd_chk(IDC_OFS_GATE, 32'h0);
    foreach (rows[i])
    begin
      wb(1'b1, IDC_OFS_CONFIG, 4'h3, {16'h0, rows[i].cfg});
      wb(1'b1, IDC_OFS_GATE, 4'h3, {16'h0, rows[i].gate});
      chk({domain_off_o, periph_off_o}, {ed, ep});
      idle();
      chk(bus_error_o, rows[i].err);
      chk({domain_off_o, periph_off_o}, {rows[i].dom, rows[i].per});
      rd_chk(IDC_OFS_STATUS, rows[i].dom);
      rd_chk(IDC_OFS_GATE_STAT, rows[i].per);
      {ed, ep} = {rows[i].dom, rows[i].per};
    end
    wb(1'b1, 16'h0100, 4'h3, 32'hffff);
    chk(e, 1'b1);
    wb(1'b1, IDC_OFS_STATUS, 4'h3, 32'h01ff);
    rd_chk(IDC_OFS_STATUS, 32'h0);
    wb(1'b1, IDC_OFS_GATE, 4'h1, 32'hffff);
    rd_chk(IDC_OFS_GATE, 32'h00ff);
    wb(1'b1, IDC_OFS_CONFIG, 4'h3, 32'hffff);
    rd_chk(IDC_OFS_CONFIG, 32'h03ff);
    idle();
    chk({domain_off_o, periph_off_o}, {9'h1ff, 14'h00ff});
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({domain_off_o, periph_off_o}, 23'h0);
    rd_chk(IDC_OFS_CONFIG, 32'h0);
    summarize();
  end
endmodule
bind idc_top idc_monitor idc_monitor_i (.*);
